// File: rtl/iflg_consts.svh
`ifndef IFLG_CONSTS_SVH
`define IFLG_CONSTS_SVH

// event array shape
`define IFLG_NUM_EVT        16
`define IFLG_NUM_TYPE       4
`define IFLG_EVT_PER_TYPE   4

// apb register byte offsets
`define IFLG_ADDR_W         12
`define IFLG_OFS_SENSE      12'h000
`define IFLG_OFS_FLAG       12'h004
`define IFLG_OFS_MASK       12'h008
`define IFLG_OFS_STATUS     12'h00c
`define IFLG_OFS_CTRL       12'h010

// control register fields
`define IFLG_CTRL_SINGLE_BIT 0
`define IFLG_CTRL_FORCE_BIT  1

// reset values
`define IFLG_MASK_RST       16'hffff
`define IFLG_EVT_ZERO       16'h0000
`define IFLG_DATA_ZERO      32'h0000_0000
`define IFLG_CTRL_RST       2'h0

`endif

// File: rtl/iflg_pkg.sv
package iflg_pkg;

    // control register; force_low sits above single_edge
    typedef struct packed {
        logic force_low;
        logic single_edge;
    } iflg_ctrl_t;

    // levels from the power sequencer
    typedef struct packed {
        logic irq_out_n_allow;
        logic system_reset_out_n_allow;
        logic powerdown_initial_delay_state_elapsed;
    } iflg_seq_t;

    typedef enum logic [0:0] {
        IFLG_APB_IDLE = 1'b0,
        IFLG_APB_ACK  = 1'b1
    } iflg_apb_st_t;

endpackage

// File: rtl/iflg_top.sv
`timescale 1ns/1ps
`include "iflg_consts.svh"
// Functional notes
// R1: dual-edge: line low on fault appear and vanish
// R2: clearing flag releases line despite live fault
// R3: single-edge: line low only on fault appearance
// R4: each event has sense, flag, mask bits
// R5: sense bit follows detector output live
// R6: dual-edge: any sense change sets flag
// R7: any unmasked set flag drives line low
// R8: writing 1 clears flag, 0 leaves it
// R9: line released once unmasked flags all clear
// R10: mask bit one removes flag from line
// R11: mask reset values come from otp
// R12: status bit per type of unmasked flags
// R13: single-edge: flag sets on sense rise only
// R14: single-edge: cleared flag reads 1 while sense high
// R15: single-edge: reads 0 after sense falls, no line
// R16: line low from startup until power-up done
// R17: flag set in power-up keeps line low
// R18: force bit one drives line low
// R19: power-down drives line and reset low after delay
// R20: host should read registers after power-up
// R21: line enabled after slots, reset after timer
// R22: masked flags still set, read and clear
module iflg_top (
    // apb slave
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [`IFLG_ADDR_W-1:0]     paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // detectors and otp
    input  wire logic [`IFLG_NUM_EVT-1:0]    evt_sense,
    input  wire logic [`IFLG_NUM_EVT-1:0]    otp_mask,
    // sequencer
    input  wire iflg_pkg::iflg_seq_t         seq,
    // pins
    output logic                             irq_out_n,
    output logic                             system_reset_out_n
);

    localparam int NE = `IFLG_NUM_EVT;

    function automatic logic [`IFLG_NUM_TYPE-1:0] grp_any(input logic [NE-1:0] v);
        logic [`IFLG_NUM_TYPE-1:0] r;
        r = '0;
        for (int t = 0; t < `IFLG_NUM_TYPE; t++) begin
            r[t] = |v[t*`IFLG_EVT_PER_TYPE +: `IFLG_EVT_PER_TYPE];
        end
        return r;
    endfunction

    function automatic logic hit(input logic [`IFLG_ADDR_W-1:0] a,
                                 input logic [`IFLG_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    iflg_pkg::iflg_apb_st_t st_ff;
    iflg_pkg::iflg_ctrl_t   ctrl_ff;
    logic [NE-1:0]          sense_ff;
    logic [NE-1:0]          prev_ff;
    logic [NE-1:0]          flag_ff;
    logic [NE-1:0]          held_ff;
    logic [NE-1:0]          mask_ff;
    logic                   otp_loaded_ff;
    logic                   irq_out_n_en_ff;
    logic                   system_reset_out_n_en_ff;
    logic                   pd_ff;
    logic [31:0]            prdata_ff;
    logic                   pready_ff;
    logic                   pslverr_ff;
    logic                   irq_n_ff;
    logic                   rst_n_ff;

    logic                   setup;
    logic                   access;
    logic                   mapped;
    logic                   wr_en;
    logic                   flag_wr;
    logic [NE-1:0]          rise;
    logic [NE-1:0]          fall;
    logic [NE-1:0]          set_vec;
    logic [NE-1:0]          clr_vec;
    logic [NE-1:0]          flag_rd;
    logic [NE-1:0]          live_vec;
    logic [`IFLG_NUM_TYPE-1:0] status_vec;
    logic [31:0]            rd_mux;
    logic [NE-1:0]          nxt_flag;
    logic [NE-1:0]          nxt_held;
    logic                   nxt_irq_n;

    // apb decode
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready_ff;
    assign mapped = hit(paddr, `IFLG_OFS_SENSE) | hit(paddr, `IFLG_OFS_FLAG)
                  | hit(paddr, `IFLG_OFS_MASK) | hit(paddr, `IFLG_OFS_STATUS)
                  | hit(paddr, `IFLG_OFS_CTRL);
    assign wr_en   = access & pwrite & mapped;
    assign flag_wr = wr_en & hit(paddr, `IFLG_OFS_FLAG);

    // edge detection on the live sense bits
    assign rise    = sense_ff & ~prev_ff;
    assign fall    = ~sense_ff & prev_ff;
    assign set_vec = ctrl_ff.single_edge ? rise : (rise | fall); // [R6] [R13] [R1] [R3]
    assign clr_vec = flag_wr ? pwdata[NE-1:0] : `IFLG_EVT_ZERO; // [R8]

    // hold term makes a cleared flag still read high while its sense stays up
    assign flag_rd    = flag_ff | (ctrl_ff.single_edge ? held_ff : `IFLG_EVT_ZERO); // [R14]
    assign live_vec   = flag_ff & ~mask_ff; // [R10] [R22]
    assign status_vec = grp_any(live_vec); // [R12]

    always_comb begin
        rd_mux = `IFLG_DATA_ZERO;
        case (1'b1)
            hit(paddr, `IFLG_OFS_SENSE):  rd_mux[NE-1:0] = sense_ff; // [R5]
            hit(paddr, `IFLG_OFS_FLAG):   rd_mux[NE-1:0] = flag_rd;
            hit(paddr, `IFLG_OFS_MASK):   rd_mux[NE-1:0] = mask_ff;
            hit(paddr, `IFLG_OFS_STATUS): rd_mux[`IFLG_NUM_TYPE-1:0] = status_vec;
            hit(paddr, `IFLG_OFS_CTRL):   rd_mux[1:0] = ctrl_ff;
            default:                      rd_mux = `IFLG_DATA_ZERO;
        endcase
    end

    // set beats a same-cycle clear so no event is lost
    always_comb begin
        nxt_flag = set_vec | (flag_ff & ~clr_vec); // [R4] [R8] [R2]
    end

    always_comb begin
        if (ctrl_ff.single_edge) begin
            nxt_held = sense_ff & (held_ff | (clr_vec & flag_ff & ~set_vec)); // [R14] [R15]
        end else begin
            nxt_held = `IFLG_EVT_ZERO;
        end
    end

    // line condition; power-up gate, power-down, force and unmasked flags
    always_comb begin
        nxt_irq_n = irq_out_n_en_ff & ~pd_ff // [R16] [R17]
                  & ~ctrl_ff.force_low // [R18]
                  & ~(|live_vec); // [R7] [R9]
    end

    // apb handshake: one wait-free access cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff      <= iflg_pkg::IFLG_APB_IDLE;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            case (st_ff)
                iflg_pkg::IFLG_APB_IDLE: begin
                    if (setup) begin
                        st_ff      <= iflg_pkg::IFLG_APB_ACK;
                        pready_ff  <= 1'b1;
                        pslverr_ff <= ~mapped;
                    end
                end
                iflg_pkg::IFLG_APB_ACK: begin
                    st_ff      <= iflg_pkg::IFLG_APB_IDLE;
                    pready_ff  <= 1'b0;
                    pslverr_ff <= 1'b0;
                end
                default: begin
                    st_ff      <= iflg_pkg::IFLG_APB_IDLE;
                    pready_ff  <= 1'b0;
                    pslverr_ff <= 1'b0;
                end
            endcase
        end
    end

    // read data captured at setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= `IFLG_DATA_ZERO;
        end else if (setup && (st_ff == iflg_pkg::IFLG_APB_IDLE)) begin
            prdata_ff <= pwrite ? `IFLG_DATA_ZERO : rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `IFLG_CTRL_RST;
        end else if (wr_en && hit(paddr, `IFLG_OFS_CTRL)) begin
            ctrl_ff.single_edge <= pwdata[`IFLG_CTRL_SINGLE_BIT];
            ctrl_ff.force_low   <= pwdata[`IFLG_CTRL_FORCE_BIT]; // [R18]
        end
    end

    // otp mask caught on the first clock after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff       <= `IFLG_MASK_RST;
            otp_loaded_ff <= 1'b0;
        end else if (!otp_loaded_ff) begin
            mask_ff       <= otp_mask; // [R11]
            otp_loaded_ff <= 1'b1;
        end else if (wr_en && hit(paddr, `IFLG_OFS_MASK)) begin
            mask_ff <= pwdata[NE-1:0];
        end
    end

    // prev starts at zero so a fault present at release counts as an edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_ff <= `IFLG_EVT_ZERO;
            prev_ff  <= `IFLG_EVT_ZERO;
        end else begin
            sense_ff <= evt_sense; // [R5]
            prev_ff  <= sense_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= `IFLG_EVT_ZERO;
            held_ff <= `IFLG_EVT_ZERO;
        end else begin
            flag_ff <= nxt_flag;
            held_ff <= nxt_held;
        end
    end

    // sequencer levels; power-down is sticky since it cannot be interrupted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out_n_en_ff <= 1'b0;
            system_reset_out_n_en_ff <= 1'b0;
            pd_ff      <= 1'b0;
        end else begin
            irq_out_n_en_ff <= seq.irq_out_n_allow; // [R21]
            system_reset_out_n_en_ff <= seq.system_reset_out_n_allow & seq.irq_out_n_allow; // [R21]
            pd_ff      <= pd_ff | seq.powerdown_initial_delay_state_elapsed; // [R19]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            irq_n_ff <= nxt_irq_n; // [R16]
            rst_n_ff <= system_reset_out_n_en_ff & ~pd_ff; // [R19]
        end
    end

    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign irq_out_n          = irq_n_ff;
    assign system_reset_out_n = rst_n_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dual_edge_set: assert property ( // [R6]
        (!ctrl_ff.single_edge && (sense_ff != prev_ff))
        |=> ((flag_ff & $past(sense_ff ^ prev_ff)) == $past(sense_ff ^ prev_ff)))
        else $error("dual edge change did not set flag");

    a_single_rise_only: assert property ( // [R13]
        ctrl_ff.single_edge
        |=> ((flag_ff & ~$past(flag_ff) & ~$past(rise)) == `IFLG_EVT_ZERO))
        else $error("single edge flag set without sense rise");

    a_write_one_clears: assert property ( // [R8]
        flag_wr |=> ((flag_ff & $past(pwdata[NE-1:0] & ~set_vec)) == `IFLG_EVT_ZERO))
        else $error("write one did not clear flag");

    a_write_zero_keeps: assert property ( // [R8]
        flag_wr
        |=> ((flag_ff & $past(flag_ff & ~pwdata[NE-1:0]))
             == $past(flag_ff & ~pwdata[NE-1:0])))
        else $error("write zero changed flag");

    a_unmasked_low: assert property ( // [R7]
        (|(flag_ff & ~mask_ff)) |=> !irq_out_n)
        else $error("unmasked flag did not pull line low");

    a_all_clear_high: assert property ( // [R9]
        (irq_out_n_en_ff && !pd_ff && !ctrl_ff.force_low && ((flag_ff & ~mask_ff) == '0))
        |=> irq_out_n)
        else $error("line held low with nothing pending");

    a_force_drives_low: assert property ( // [R18]
        ctrl_ff.force_low |=> !irq_out_n)
        else $error("force bit did not pull line low");

    a_startup_low: assert property ( // [R16]
        !seq.irq_out_n_allow |=> ##1 !irq_out_n)
        else $error("line released before power-up done");

    a_pd_low: assert property ( // [R19]
        seq.powerdown_initial_delay_state_elapsed |=> ##1 (!irq_out_n && !system_reset_out_n)[*3])
        else $error("power-down did not pull line and reset low");

    a_single_held: assert property ( // [R14]
        (ctrl_ff.single_edge && flag_wr && |(pwdata[NE-1:0] & flag_ff & evt_sense & sense_ff))
        |=> |(flag_rd & sense_ff))
        else $error("cleared single edge flag read back zero while sense high");

    a_status_type: assert property ( // [R12]
        (status_vec[0] == |(flag_ff[3:0] & ~mask_ff[3:0]))
        && (status_vec[1] == |(flag_ff[7:4] & ~mask_ff[7:4]))
        && (status_vec[2] == |(flag_ff[11:8] & ~mask_ff[11:8]))
        && (status_vec[3] == |(flag_ff[15:12] & ~mask_ff[15:12])))
        else $error("status bit disagrees with unmasked flags");

    a_apb_ready: assert property (
        (setup && st_ff == iflg_pkg::IFLG_APB_IDLE) |=> (pready && !$past(pready)))
        else $error("apb access not answered in one cycle");

    a_apb_err: assert property (
        (setup && st_ff == iflg_pkg::IFLG_APB_IDLE && !mapped) |=> (pready && pslverr))
        else $error("unmapped access not flagged as error");

    a_clear_releases: assert property ( // [R2]
        (flag_wr && seq.irq_out_n_allow && !pd_ff && !seq.powerdown_initial_delay_state_elapsed
         && !ctrl_ff.force_low && (set_vec == '0)
         && ((flag_ff & ~mask_ff & ~pwdata[NE-1:0]) == '0))
        |=> ##1 irq_out_n)
        else $error("clearing flag did not release line");

    a_irq_needs_allow: assert property ( // [R16]
        irq_out_n |-> ($past(seq.irq_out_n_allow, 2) && !$past(pd_ff) && !$past(ctrl_ff.force_low)))
        else $error("line released without power-up done");

    a_rst_gate: assert property ( // [R21]
        !seq.irq_out_n_allow |=> ##1 !system_reset_out_n)
        else $error("reset out released before line enable");

    a_flag_sticky: assert property ( // [R17]
        ((|live_vec) && !wr_en) |=> (|live_vec))
        else $error("pending flag vanished without a write");

    a_sense_follows: assert property ( // [R5]
        1'b1 |=> (sense_ff == $past(evt_sense)))
        else $error("sense bit does not follow detector");

    a_held_drops: assert property ( // [R15]
        ctrl_ff.single_edge |=> ((held_ff & ~$past(sense_ff)) == '0))
        else $error("held flag kept after sense fell");

    a_dual_no_hold: assert property ( // [R1]
        !ctrl_ff.single_edge |=> (held_ff == '0))
        else $error("hold term active in dual edge mode");

    a_single_rise_sets: assert property ( // [R13]
        (ctrl_ff.single_edge && (rise != '0))
        |=> ((flag_ff & $past(rise)) == $past(rise)))
        else $error("single edge rise did not set flag");

    a_ctrl_write: assert property ( // [R18]
        (wr_en && hit(paddr, `IFLG_OFS_CTRL))
        |=> (ctrl_ff.force_low == $past(pwdata[`IFLG_CTRL_FORCE_BIT])))
        else $error("force bit write did not land");

    a_mask_write: assert property ( // [R10]
        (otp_loaded_ff && wr_en && hit(paddr, `IFLG_OFS_MASK))
        |=> (mask_ff == $past(pwdata[NE-1:0])))
        else $error("mask write did not land");

    c_dual_fall: cover property (!ctrl_ff.single_edge && fall[0] ##1 flag_ff[0]);
    c_single_held: cover property (ctrl_ff.single_edge && held_ff[0] ##[1:20] !held_ff[0]);
    c_force: cover property (ctrl_ff.force_low && irq_out_n_en_ff ##1 !irq_out_n);
    c_pd: cover property (irq_out_n_en_ff && irq_out_n ##1 pd_ff);
    c_clear_live: cover property (flag_wr && (sense_ff != '0) ##2 irq_out_n);

endmodule

// File: verif/iflg_seq_model.sv
`timescale 1ns/1ps
// power sequencer levels seen by the interrupt logic
module iflg_seq_model #(
    parameter int PU_DLY  = 4,
    parameter int RST_DLY = 3,
    parameter int PD_DLY  = 5
) (
    // clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // requests from the bench
    input  wire logic            pu_go,
    input  wire logic            pd_go,
    // levels to the block
    output iflg_pkg::iflg_seq_t  seq
);
    int cnt_pu_ff;
    int cnt_pd_ff;

    // counters saturate so a long run cannot wrap back below the limits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_pu_ff <= 0;
            cnt_pd_ff <= 0;
        end else begin
            if (pu_go && cnt_pu_ff < 255) cnt_pu_ff <= cnt_pu_ff + 1;
            if (pd_go && cnt_pd_ff < 255) cnt_pd_ff <= cnt_pd_ff + 1;
        end
    end

    assign seq.irq_out_n_allow      = (cnt_pu_ff >= PU_DLY);
    assign seq.system_reset_out_n_allow      = (cnt_pu_ff >= PU_DLY + RST_DLY);
    assign seq.powerdown_initial_delay_state_elapsed = (cnt_pd_ff >= PD_DLY);
endmodule

// File: verif/iflg_top_tb.sv
`timescale 1ns/1ps
`include "iflg_consts.svh"
module iflg_top_tb;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, pu_go, pd_go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] evt_sense, otp_mask, b, m;
    logic        irq_out_n, system_reset_out_n;
    iflg_pkg::iflg_seq_t seq;
    logic [32:0] q[$];
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          i;
    integer      seed;

    always #50 pclk = ~pclk;

    iflg_seq_model i_iflg_seq_model (.pclk(pclk), .presetn(presetn), .pu_go(pu_go),
        .pd_go(pd_go), .seq(seq));
    iflg_top i_iflg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt_sense(evt_sense), .otp_mask(otp_mask), .seq(seq),
        .irq_out_n(irq_out_n), .system_reset_out_n(system_reset_out_n));

    task complete_run;
        if (mismatches == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d});
    endtask

    task rd(input logic [11:0] a, input logic [15:0] e);
        q.push_back({17'h00000, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task pin(input logic e);
        chk("irq_out_n", {32'h0, e}, {32'h0, irq_out_n});
    endtask

    // read data compared when the access phase completes
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (q.size() == 0) chk("read queue", 33'h0, 33'h1_ffff_ffff);
            else chk("prdata", q.pop_front(), {pslverr, prdata});
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    initial begin
        seed = 32'h8645271e;
        {presetn, psel, penable, pwrite, pu_go, pd_go} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        evt_sense = 16'h0000;
        otp_mask = 16'($random(seed));
        cyc(10);
        pin(1'b0);
        presetn <= 1'b1;
        cyc(3);
        rd(`IFLG_OFS_MASK, otp_mask);
        m = 16'($random(seed));
        wr(`IFLG_OFS_MASK, m);
        rd(`IFLG_OFS_MASK, m);
        wr(`IFLG_OFS_MASK, 16'h0000);
        evt_sense <= 16'h0008;
        cyc(5);
        pin(1'b0);
        pu_go <= 1'b1;
        cyc(12);
        pin(1'b0);
        chk("system_reset_out_n", 33'h1, {32'h0, system_reset_out_n});
        rd(`IFLG_OFS_STATUS, 16'h0001);
        wr(`IFLG_OFS_FLAG, 16'h0008);
        cyc(2);
        pin(1'b1);
        evt_sense <= 16'h0000;
        cyc(5);
        wr(`IFLG_OFS_FLAG, 16'h0008);
        for (i = 0; i < 16; i++) begin
            b = 16'h0001 << i;
            evt_sense <= b;
            cyc(5);
            pin(1'b0);
            rd(`IFLG_OFS_SENSE, b);
            rd(`IFLG_OFS_FLAG, b);
            rd(`IFLG_OFS_STATUS, 16'h0001 << (i / 4));
            wr(`IFLG_OFS_FLAG, ~b);
            rd(`IFLG_OFS_FLAG, b);
            wr(`IFLG_OFS_FLAG, b);
            cyc(2);
            pin(1'b1);
            rd(`IFLG_OFS_FLAG, 16'h0000);
            evt_sense <= 16'h0000;
            cyc(5);
            pin(1'b0);
            rd(`IFLG_OFS_FLAG, b);
            wr(`IFLG_OFS_FLAG, b);
            cyc(2);
            pin(1'b1);
        end
        b = 16'h0001 << ($random(seed) & 15);
        wr(`IFLG_OFS_MASK, b);
        evt_sense <= b;
        cyc(5);
        pin(1'b1);
        rd(`IFLG_OFS_FLAG, b);
        rd(`IFLG_OFS_STATUS, 16'h0000);
        wr(`IFLG_OFS_MASK, 16'h0000);
        cyc(3);
        pin(1'b0);
        evt_sense <= 16'h0000;
        wr(`IFLG_OFS_CTRL, 16'h0001);
        rd(`IFLG_OFS_CTRL, 16'h0001);
        wr(`IFLG_OFS_FLAG, b);
        cyc(5);
        pin(1'b1);
        evt_sense <= b;
        cyc(5);
        pin(1'b0);
        wr(`IFLG_OFS_FLAG, b);
        cyc(2);
        pin(1'b1);
        rd(`IFLG_OFS_FLAG, b);
        evt_sense <= 16'h0000;
        cyc(5);
        pin(1'b1);
        rd(`IFLG_OFS_FLAG, 16'h0000);
        wr(`IFLG_OFS_CTRL, 16'h0002);
        cyc(3);
        pin(1'b0);
        rd(`IFLG_OFS_CTRL, 16'h0002);
        wr(`IFLG_OFS_CTRL, 16'h0000);
        cyc(3);
        pin(1'b1);
        q.push_back({1'b1, 32'h0000_0000});
        apb(1'b0, 12'h014, 32'h0000_0000);
        pd_go <= 1'b1;
        cyc(10);
        pin(1'b0);
        chk("system_reset_out_n", 33'h0, {32'h0, system_reset_out_n});
        cyc(3);
        complete_run();
    end
endmodule
